// [hw/charger_ctrl_consts.svh]
// Notes on behaviour
// - any fault event sets its status bit; an unmasked one also pulls the request line low
// - any access to a fault status register releases the request line
// - status bit clears only by reading its own status register, except the self-clearing over-temperature bit
// - persisting failure keeps its bit set but raises no new request
// - over-temperature bit clears itself once the die has cooled
// - masks gate the request line only, never the status bits
// - shunt monitor off after reset, on when host sets enable bit
// - charge, boost and high-impedance modes; start in high impedance
// - charging fault clears charge field, sets second status, enters hiz
// - after charging fault restart by host or by bus supply re-plug
// - detected input limit defaults to 500 mA
// - wait 200 ms after bus supply appears, then identify source
// - dedicated charger raises detected limit to 975 mA, else 500 mA
// - automatic identification only while io supply is below 0.6 V
// - host may start identification any time via start bit; the code acts on it only while the detector is idle
// - start bit self-clears and detector disconnects when finished
// - two-bit limit field selects 100, 500, 975 mA or no limit
// - effective limit is higher of detected and programmed limit
// - bus supply undervoltage resets programmed limit to 100 mA
// - ignore-detect bit applies programmed limit only
`ifndef CHARGER_CTRL_CONSTS_SVH
`define CHARGER_CTRL_CONSTS_SVH
`define ADDR_CONTROL 8'h00
`define ADDR_CONFIG 8'h04
`define ADDR_STATUS_FIRST 8'h08
`define ADDR_STATUS_SECOND 8'h0C
`define ADDR_STATUS_THIRD 8'h10
`define ADDR_SUPPRESS_FIRST 8'h14
`define ADDR_SUPPRESS_SECOND 8'h18
`define ADDR_SUPPRESS_THIRD 8'h1C
`define ADDR_STATE 8'h20
`define CTL_SHUNT_BIT 0
`define CTL_DETECT_BIT 1
`define CTL_CHARGE_LSB 2
`define CTL_BOOST_BIT 4
`define CFG_IGNORE_BIT 2
`define OVERTEMP_BIT 0
`define CHARGE_FAULT_GROUP 1
`define LIMIT_100MA 2'h0
`define LIMIT_500MA 2'h1
`define LIMIT_975MA 2'h2
`define LIMIT_NONE 2'h3
`define CHARGE_OFF 2'h0
`define MASK_RESET 8'h00
`define SETTLE_MS 200
`define CLK_MHZ 125
`define DETECT_EDGES 4'h8
`endif

// [hw/charger_ctrl_pkg.sv]
package charger_ctrl_pkg;
  typedef enum logic [1:0]
  {
    MODE_HIZ = 2'b00,
    MODE_CHARGE = 2'b01,
    MODE_BOOST = 2'b10
  } charger_mode_t;
  typedef enum logic [1:0]
  {
    DET_IDLE = 2'b00,
    DET_SETTLE = 2'b01,
    DET_RUN = 2'b10
  } detect_state_t;
  typedef struct packed
  {
    logic pass_switch_on;
    logic charge_pwm_on;
    logic boost_on;
  } power_stage_t;
  typedef logic [7:0] fault_vec_t;
endpackage : charger_ctrl_pkg

// [hw/charger_fault_and_input_limit_ctrl.sv]
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "charger_ctrl_consts.svh"
module charger_fault_and_input_limit_ctrl
  import charger_ctrl_pkg::*;
#(
  parameter int SETTLE_CYCLES = `SETTLE_MS * 1000 * `CLK_MHZ
)
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire fault_vec_t fault_first, // async fault levels, group 1
  input wire fault_vec_t fault_second, // async fault levels, group 2
  input wire fault_vec_t fault_third, // async fault levels, group 3
  input wire logic vbus_present, // bus supply present
  input wire logic vbus_uvlo, // bus supply below lockout
  input wire logic io_supply_level, // high when io supply above 0.6 V
  input wire logic detect_clk, // detector sample clock
  input wire logic dedicated_seen, // detector sees dedicated charger
  output logic req_out, // request pin output value
  output logic req_oe_n, // request pin enable, low drives
  output power_stage_t stage, // power stage enables
  output charger_mode_t mode, // current operating mode
  output logic shunt_meter_on, // shunt monitor enable
  output logic detect_connect, // detector on data lines
  output logic [1:0] limit_code // effective input limit code
);

  localparam logic [24:0] SETTLE_LAST = 25'(SETTLE_CYCLES - 1);

  logic [23:0] cond_meta;
  logic [23:0] cond_sync;
  logic [23:0] cond_prev;
  logic [3:0] lvl_meta;
  logic [3:0] lvl_sync;
  logic clk_prev;
  logic vbus_prev;
  fault_vec_t fault_status [3];
  fault_vec_t event_suppress [3];
  fault_vec_t rise [3];
  logic [2:0] unmasked;
  logic source_detect_start;
  logic boost_request;
  logic [1:0] charge_run_field;
  logic [1:0] saved_charge;
  logic stopped_by_fault;
  logic [1:0] input_limit_select;
  logic ignore_detect_result;
  logic detect_dcp;
  detect_state_t det_state;
  logic [24:0] settle_cnt;
  logic [3:0] edge_cnt;
  logic dcp_votes;
  logic setup;
  logic done;
  logic status_access;
  logic [2:0] read_clear;
  logic charge_fault;
  logic vbus_ok;
  logic vbus_rise;
  logic clk_rise;
  charger_mode_t next_mode;

  // register index of an address, 4'hF when unmapped
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    case (a)
      `ADDR_CONTROL: reg_index = 4'h0;
      `ADDR_CONFIG: reg_index = 4'h1;
      `ADDR_STATUS_FIRST: reg_index = 4'h2;
      `ADDR_STATUS_SECOND: reg_index = 4'h3;
      `ADDR_STATUS_THIRD: reg_index = 4'h4;
      `ADDR_SUPPRESS_FIRST: reg_index = 4'h5;
      `ADDR_SUPPRESS_SECOND: reg_index = 4'h6;
      `ADDR_SUPPRESS_THIRD: reg_index = 4'h7;
      `ADDR_STATE: reg_index = 4'h8;
      default: reg_index = 4'hF;
    endcase
  endfunction : reg_index

  // larger of two ascending limit codes
  function automatic logic [1:0] max_limit(input logic [1:0] a,
                                           input logic [1:0] b);
    max_limit = (a > b) ? a : b;
  endfunction : max_limit

  // two-stage synchronisers for every asynchronous pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cond_meta <= 24'h000000;
      cond_sync <= 24'h000000;
      cond_prev <= 24'h000000;
      lvl_meta <= 4'h0;
      lvl_sync <= 4'h0;
      clk_prev <= 1'b0;
      vbus_prev <= 1'b0;
    end
    else
    begin
      cond_meta <= {fault_third, fault_second, fault_first};
      cond_sync <= cond_meta;
      cond_prev <= cond_sync;
      lvl_meta <= {dedicated_seen, detect_clk, io_supply_level, vbus_ok};
      lvl_sync <= lvl_meta;
      clk_prev <= lvl_sync[2];
      vbus_prev <= lvl_sync[0];
    end
  end

  // vbus_ok combines two pins before the first flop on purpose
  assign vbus_ok = vbus_present & ~vbus_uvlo;
  assign vbus_rise = lvl_sync[0] & ~vbus_prev;
  assign clk_rise = lvl_sync[2] & ~clk_prev;

  // zero-wait slave is avoided: one wait state keeps prdata a flop
  assign setup = psel & penable & ~pready;
  assign done = psel & penable & pready;
  assign status_access = done && (reg_index(paddr) >= 4'h2)
                         && (reg_index(paddr) <= 4'h4);

  // per-group edge detection, clearing and request gating
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : grp
      assign rise[g] = cond_sync[g*8 +: 8] & ~cond_prev[g*8 +: 8];
      assign read_clear[g] = done && !pwrite
                             && (reg_index(paddr) == 4'(g + 2));
      assign unmasked[g] = |(rise[g] & ~event_suppress[g]);

      // sticky bits; a live condition sets again, beating the clear
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          fault_status[g] <= 8'h00;
        else
        begin
          fault_status[g] <= (fault_status[g] & ~{8{read_clear[g]}})
                             | cond_sync[g*8 +: 8];
          if (g == 0)
            fault_status[g][`OVERTEMP_BIT] <= cond_sync[`OVERTEMP_BIT];
        end
      end
    end
  endgenerate

  assign charge_fault = (mode == MODE_CHARGE)
                        && (|rise[`CHARGE_FAULT_GROUP]);

  // open-drain request: new unmasked edge wins over a status access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_oe_n <= 1'b1;
      req_out <= 1'b0;
    end
    else if (|unmasked)
      req_oe_n <= 1'b0;
    else if (status_access)
      req_oe_n <= 1'b1;
  end

  // apb handshake and read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && (reg_index(paddr) == 4'hF);
      if (setup && !pwrite)
      begin
        case (reg_index(paddr))
          4'h0: prdata <= {27'h0000000, boost_request, charge_run_field,
                           source_detect_start, shunt_meter_on};
          4'h1: prdata <= {29'h00000000, ignore_detect_result,
                           input_limit_select};
          4'h2: prdata <= {24'h000000, fault_status[0]};
          4'h3: prdata <= {24'h000000, fault_status[1]};
          4'h4: prdata <= {24'h000000, fault_status[2]};
          4'h5: prdata <= {24'h000000, event_suppress[0]};
          4'h6: prdata <= {24'h000000, event_suppress[1]};
          4'h7: prdata <= {24'h000000, event_suppress[2]};
          4'h8: prdata <= {26'h0000000, det_state, detect_dcp,
                           limit_code[1], limit_code[0], ~req_oe_n};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // mask registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      event_suppress[0] <= `MASK_RESET;
      event_suppress[1] <= `MASK_RESET;
      event_suppress[2] <= `MASK_RESET;
    end
    else if (done && pwrite)
    begin
      case (reg_index(paddr))
        4'h5: event_suppress[0] <= pwdata[7:0];
        4'h6: event_suppress[1] <= pwdata[7:0];
        4'h7: event_suppress[2] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // control register; charging fault forces the charge field off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shunt_meter_on <= 1'b0;
      boost_request <= 1'b0;
      charge_run_field <= `CHARGE_OFF;
      saved_charge <= `CHARGE_OFF;
      stopped_by_fault <= 1'b0;
    end
    else if (charge_fault)
    begin
      saved_charge <= charge_run_field;
      charge_run_field <= `CHARGE_OFF;
      stopped_by_fault <= 1'b1;
    end
    else if (done && pwrite && reg_index(paddr) == 4'h0)
    begin
      shunt_meter_on <= pwdata[`CTL_SHUNT_BIT];
      boost_request <= pwdata[`CTL_BOOST_BIT];
      charge_run_field <= pwdata[`CTL_CHARGE_LSB +: 2];
      stopped_by_fault <= 1'b0;
    end
    else if (vbus_rise && stopped_by_fault)
    begin
      charge_run_field <= saved_charge;
      stopped_by_fault <= 1'b0;
    end
  end

  // configuration register; undervoltage keeps the limit at 100 mA
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_limit_select <= `LIMIT_100MA;
      ignore_detect_result <= 1'b0;
    end
    else
    begin
      if (done && pwrite && reg_index(paddr) == 4'h1)
      begin
        input_limit_select <= pwdata[1:0];
        ignore_detect_result <= pwdata[`CFG_IGNORE_BIT];
      end
      if (!lvl_sync[0])
        input_limit_select <= `LIMIT_100MA;
    end
  end

  // source identification; host start wins over automatic settle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      det_state <= DET_IDLE;
      settle_cnt <= 25'h0000000;
      edge_cnt <= 4'h0;
      dcp_votes <= 1'b0;
      detect_dcp <= 1'b0;
      source_detect_start <= 1'b0;
      detect_connect <= 1'b0;
    end
    else
    begin
      if (done && pwrite && reg_index(paddr) == 4'h0
          && pwdata[`CTL_DETECT_BIT])
        source_detect_start <= 1'b1;
      case (det_state)
        DET_IDLE:
        begin
          if (source_detect_start)
          begin
            det_state <= DET_RUN;
            detect_connect <= 1'b1;
            edge_cnt <= 4'h0;
            dcp_votes <= 1'b1;
          end
          else if (vbus_rise && !lvl_sync[1])
          begin
            det_state <= DET_SETTLE;
            settle_cnt <= 25'h0000000;
          end
        end
        DET_SETTLE:
        begin
          if (!lvl_sync[0])
            det_state <= DET_IDLE;
          else if (settle_cnt == SETTLE_LAST)
          begin
            det_state <= DET_RUN;
            detect_connect <= 1'b1;
            edge_cnt <= 4'h0;
            dcp_votes <= 1'b1;
          end
          else
            settle_cnt <= settle_cnt + 25'h0000001;
        end
        DET_RUN:
        begin
          // a stopped detector clock stalls here until reset; host start does not retry
          if (clk_rise)
          begin
            edge_cnt <= edge_cnt + 4'h1;
            dcp_votes <= dcp_votes & lvl_sync[3];
            if (edge_cnt == `DETECT_EDGES - 4'h1)
            begin
              detect_dcp <= dcp_votes & lvl_sync[3];
              source_detect_start <= 1'b0;
              detect_connect <= 1'b0;
              det_state <= DET_IDLE;
            end
          end
        end
        default: det_state <= DET_IDLE;
      endcase
    end
  end

  // operating mode selection
  always_comb
  begin
    if (charge_run_field != `CHARGE_OFF && lvl_sync[0] && !charge_fault)
      next_mode = MODE_CHARGE;
    else if (boost_request && !lvl_sync[0])
      next_mode = MODE_BOOST;
    else
      next_mode = MODE_HIZ;
  end

  // registered mode, stage enables and limit code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= MODE_HIZ;
      stage <= '0;
      limit_code <= `LIMIT_500MA;
    end
    else
    begin
      mode <= next_mode;
      stage.pass_switch_on <= (next_mode == MODE_CHARGE);
      stage.charge_pwm_on <= (next_mode == MODE_CHARGE);
      stage.boost_on <= (next_mode == MODE_BOOST);
      if (ignore_detect_result)
        limit_code <= input_limit_select;
      else
        limit_code <= max_limit(input_limit_select,
                                detect_dcp ? `LIMIT_975MA : `LIMIT_500MA);
    end
  end

endmodule : charger_fault_and_input_limit_ctrl
`default_nettype wire

// [test/charger_ctrl_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "charger_ctrl_consts.svh"
module charger_ctrl_checker
  import charger_ctrl_pkg::*;
#(
  parameter int SETTLE_CYCLES = 50
)
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire fault_vec_t fault_first, // fault group 1
  input wire fault_vec_t fault_second, // fault group 2
  input wire fault_vec_t fault_third, // fault group 3
  input wire logic req_out, // request pin value
  input wire logic req_oe_n, // request pin enable
  input wire power_stage_t stage, // power stage
  input wire charger_mode_t mode, // mode
  input wire logic shunt_meter_on, // shunt enable
  input wire logic [1:0] limit_code // effective limit
);
  logic [23:0] fprev;
  logic [2:0] quiet;
  logic ctl_wr1;
  logic done;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign done = psel && penable && pready;
  // cycles since any fault level last moved, saturating
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      fprev <= 24'h0;
      quiet <= 3'h0;
    end
    else
    begin
      fprev <= {fault_first, fault_second, fault_third};
      if ({fault_first, fault_second, fault_third} != fprev)
        quiet <= 3'h0;
      else if (quiet != 3'h7)
        quiet <= quiet + 3'h1;
    end
  // completed write of shunt enable, a cycle old
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctl_wr1 <= 1'b0;
    else
      ctl_wr1 <= done && pwrite && paddr == `ADDR_CONTROL && pwdata[0];
  property p_req_out;
    req_out == 1'b0;
  endproperty
  a_req_out: assert property (p_req_out)
    else $error("request pin value not low");
  property p_req_release;
    done && quiet == 3'h7 && (paddr == `ADDR_STATUS_FIRST ||
      paddr == `ADDR_STATUS_SECOND || paddr == `ADDR_STATUS_THIRD)
      |=> req_oe_n;
  endproperty
  a_req_release: assert property (p_req_release)
    else $error("request kept after status access");
  property p_req_cause;
    $fell(req_oe_n) |-> quiet < 3'h6;
  endproperty
  a_req_cause: assert property (p_req_cause)
    else $error("request without a new event");
  property p_shunt_on;
    $rose(shunt_meter_on) |-> ctl_wr1;
  endproperty
  a_shunt_on: assert property (p_shunt_on)
    else $error("shunt monitor on without enable write");
  property p_hiz_stage;
    mode == MODE_HIZ |-> stage == 3'h0;
  endproperty
  a_hiz_stage: assert property (p_hiz_stage)
    else $error("power stage active in high impedance");
  property p_start;
    $rose(presetn) |-> mode == MODE_HIZ && !shunt_meter_on &&
      limit_code == `LIMIT_500MA;
  endproperty
  a_start: assert property (p_start)
    else $error("wrong state after reset");
  property p_chg_fault;
    mode == MODE_CHARGE && (fault_second & ~fprev[15:8]) != 8'h00
      |-> ##[1:8] mode == MODE_HIZ;
  endproperty
  a_chg_fault: assert property (p_chg_fault)
    else $error("charging fault did not stop charging");
  property p_slverr;
    pslverr |-> pready;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("error without ready");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
endmodule : charger_ctrl_checker
bind charger_fault_and_input_limit_ctrl charger_ctrl_checker
  #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .fault_first,
  .fault_second, .fault_third, .req_out, .req_oe_n, .stage, .mode,
  .shunt_meter_on, .limit_code);
`default_nettype wire

// [test/charger_env_model.sv]
`timescale 1ns/1ps
`default_nettype none
module charger_env_model
(
  input wire logic detect_connect, // detector on data lines
  input wire logic dcp, // far end is a dedicated charger
  input wire logic req_out, // request pin value
  input wire logic req_oe_n, // request pin enable
  output logic detect_clk, // detector clock
  output var logic dedicated_seen = 1'b0, // detector result line
  output logic req_pin // request wire level
);
  // detector clock runs only while connected, off pclk phase
  initial
  begin
    detect_clk = 1'b0;
    #3;
    forever
    begin
      #80;
      detect_clk = detect_connect ? ~detect_clk : 1'b0;
    end
  end
  // released line toggles so no stale value is seen
  always #8 dedicated_seen = detect_connect ? dcp : ~dedicated_seen;
  // pull-up on the open-drain request wire
  assign req_pin = req_oe_n ? 1'b1 : req_out;
endmodule : charger_env_model
`default_nettype wire

// [test/tb_charger_fault_and_input_limit_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "charger_ctrl_consts.svh"
module tb_charger_fault_and_input_limit_ctrl
  import charger_ctrl_pkg::*;
;
  localparam int SETTLE = 50;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, vbus_present = 1'b0, vbus_uvlo = 1'b0;
  logic io_supply_level = 1'b1, dcp = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, req_out, req_oe_n, req_pin;
  logic detect_clk, dedicated_seen, shunt_meter_on, detect_connect;
  fault_vec_t fault_first = 8'h00, fault_second = 8'h00;
  fault_vec_t fault_third = 8'h00;
  power_stage_t stage;
  charger_mode_t mode;
  logic [1:0] limit_code, p;
  int mismatches = 0, cmp_count = 0, seed = 32'h1ec7, n, b, c;
  charger_fault_and_input_limit_ctrl #(.SETTLE_CYCLES(SETTLE)) dut_u
    (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fault_first, .fault_second,
    .fault_third, .vbus_present, .vbus_uvlo, .io_supply_level,
    .detect_clk, .dedicated_seen, .req_out, .req_oe_n, .stage, .mode,
    .shunt_meter_on, .detect_connect, .limit_code);
  charger_env_model env_u (.detect_connect, .dcp, .req_out, .req_oe_n,
    .detect_clk, .dedicated_seen, .req_pin);
  // clock
  always #4 pclk = ~pclk;
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no assumed latency: only the watchdog ends a stuck transfer
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic give_verdict;
    $display("counts: %0d mismatches, %0d compares", mismatches,
      cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  function automatic logic [1:0] exp_lim(input logic [1:0] q,
    input logic ign, input logic [1:0] d);
    return ign ? q : (q > d ? q : d);
  endfunction : exp_lim
  // watchdog, far beyond the several hundred cycles needed
  initial
  begin
    #200000;
    mismatches++;
    give_verdict;
  end
  // main sequence
  initial
  begin
    tick(3);
    presetn <= 1'b1;
    b = 1 + ($unsigned($random(seed)) % 7);
    apb(1'b0, `ADDR_CONFIG, 32'h0, rd, err);
    chk(rd, 32'h0);
    apb(1'b0, `ADDR_SUPPRESS_FIRST, 32'h0, rd, err);
    chk(rd, `MASK_RESET);
    chk(limit_code, `LIMIT_500MA);
    chk({shunt_meter_on, stage, mode}, 6'h0);
    apb(1'b0, 8'h24, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `ADDR_CONTROL, 32'h1, rd, err);
    tick(2);
    chk(shunt_meter_on, 1'b1);
    $display("done: reset and registers");
    fault_first[b] <= 1'b1;
    for (n = 0; n < 20 && req_pin !== 1'b0; n++) tick(1);
    chk(req_pin, 1'b0);
    apb(1'b0, `ADDR_STATUS_SECOND, 32'h0, rd, err);
    tick(2);
    chk(req_pin, 1'b1);
    apb(1'b0, `ADDR_STATUS_FIRST, 32'h0, rd, err);
    chk(rd[b], 1'b1);
    tick(10);
    chk(req_pin, 1'b1);
    fault_first[b] <= 1'b0;
    tick(5);
    apb(1'b0, `ADDR_STATUS_THIRD, 32'h0, rd, err);
    apb(1'b0, `ADDR_STATUS_FIRST, 32'h0, rd, err);
    chk(rd[b], 1'b1);
    apb(1'b0, `ADDR_STATUS_FIRST, 32'h0, rd, err);
    chk(rd, 32'h0);
    fault_first[0] <= 1'b1;
    tick(8);
    apb(1'b0, `ADDR_STATUS_FIRST, 32'h0, rd, err);
    chk(rd[0], 1'b1);
    fault_first[0] <= 1'b0;
    tick(6);
    apb(1'b0, `ADDR_STATUS_FIRST, 32'h0, rd, err);
    chk(rd[0], 1'b0);
    apb(1'b1, `ADDR_SUPPRESS_FIRST, 32'h1 << b, rd, err);
    fault_first[b] <= 1'b1;
    tick(10);
    chk(req_pin, 1'b1);
    apb(1'b0, `ADDR_STATUS_FIRST, 32'h0, rd, err);
    chk(rd[b], 1'b1);
    fault_first[b] <= 1'b0;
    $display("done: events");
    vbus_present <= 1'b1;
    tick(5);
    apb(1'b1, `ADDR_CONTROL, 32'hD, rd, err);
    tick(3);
    chk({stage, mode}, {3'b110, MODE_CHARGE});
    fault_second[b] <= 1'b1;
    tick(10);
    chk({req_pin, mode}, {1'b0, MODE_HIZ});
    apb(1'b0, `ADDR_CONTROL, 32'h0, rd, err);
    chk(rd[3:2], `CHARGE_OFF);
    apb(1'b0, `ADDR_STATUS_SECOND, 32'h0, rd, err);
    chk(rd[b], 1'b1);
    fault_second[b] <= 1'b0;
    vbus_present <= 1'b0;
    tick(5);
    vbus_present <= 1'b1;
    tick(5);
    apb(1'b0, `ADDR_CONTROL, 32'h0, rd, err);
    chk(rd[3:2], 2'h3);
    $display("done: charging fault");
    dcp <= 1'b1;
    apb(1'b1, `ADDR_CONTROL, 32'h3, rd, err);
    for (n = 0; n < 20 && detect_connect !== 1'b1; n++) tick(1);
    chk(detect_connect, 1'b1);
    for (n = 0; n < 2000 && detect_connect !== 1'b0; n++) tick(1);
    tick(3);
    chk(limit_code, `LIMIT_975MA);
    apb(1'b0, `ADDR_CONTROL, 32'h0, rd, err);
    chk(rd[1], 1'b0);
    c = $random(seed);
    for (n = 0; n < 8; n++)
    begin
      p = n[1:0] + c[1:0];
      apb(1'b1, `ADDR_CONFIG, {29'h0, n[2], p}, rd, err);
      tick(2);
      chk(limit_code, exp_lim(p, n[2], `LIMIT_975MA));
    end
    vbus_uvlo <= 1'b1;
    tick(5);
    apb(1'b0, `ADDR_CONFIG, 32'h0, rd, err);
    chk(rd[1:0], `LIMIT_100MA);
    vbus_uvlo <= 1'b0;
    tick(3);
    apb(1'b1, `ADDR_CONFIG, 32'h0, rd, err);
    $display("done: host detection and limits");
    dcp <= 1'b0;
    io_supply_level <= 1'b0;
    vbus_present <= 1'b0;
    tick(5);
    vbus_present <= 1'b1;
    for (n = 0; n < 500 && detect_connect !== 1'b1; n++) tick(1);
    chk(n >= SETTLE && n < 500, 1'b1);
    for (n = 0; n < 2000 && detect_connect !== 1'b0; n++) tick(1);
    tick(3);
    chk(limit_code, `LIMIT_500MA);
    io_supply_level <= 1'b1;
    vbus_present <= 1'b0;
    tick(5);
    vbus_present <= 1'b1;
    c = 0;
    for (n = 0; n < 100; n++)
    begin
      tick(1);
      if (detect_connect === 1'b1)
        c = 1;
    end
    chk(c, 0);
    // boost only runs with the bus supply gone
    vbus_present <= 1'b0;
    tick(3);
    apb(1'b1, `ADDR_CONTROL, 32'h10, rd, err);
    tick(2);
    chk({stage, mode}, {3'b001, MODE_BOOST});
    $display("done: automatic detection");
    give_verdict;
  end
endmodule : tb_charger_fault_and_input_limit_ctrl
`default_nettype wire
